// ### event_source.sv
// Far side event pin source that keeps the pulse width and spacing
module event_source (
    input  wire logic CLK,
    input  wire logic fire,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ps;
    int left = 0;
    // A fire while a pulse is still in flight is ignored, so spacing cannot shrink
    always @(posedge CLK) begin
        if (left != 0)
            left <= left - 1;
        else if (fire)
            left <= 48;
    end
    // Low 24 CLK, then at least 24 CLK high; the line idles high like a pull-up
    assign pin = !(left > 24);
endmodule // event_source

// ### test_clock_divider_timer_counter.sv
// Self-checking bench for the clock divider and timer/counter
module test_clock_divider_timer_counter;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic        fire = 1'h0, sense = 1'h1, ext_n = 1'h1, ready, slverr, err, so, soe_n;
    logic        evt, ale, irq;
    logic [2:0]  vec;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    int          error_cnt = 0;
    int          n_tests = 0;
    // The sense pin carries our level unless the block drives it
    wire         pin0 = soe_n ? sense : so;
    timer_counter timer_counter_i (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(ready),
        .PSLVERR(slverr), .SENSE_CLOCK_PIN_I(pin0), .SENSE_CLOCK_PIN_O(so),
        .SENSE_CLOCK_PIN_OE_N(soe_n), .EVENT_SENSE_PIN(evt), .EXT_INT_N(ext_n),
        .ALE(ale), .IRQ(irq), .IRQ_VECTOR(vec));
    event_source event_source_i (.CLK(clk), .fire(fire), .pin(evt));
    initial forever #12.5 clk = ~clk;
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // No cycle count is assumed; only the watchdog ends a stuck access
        do begin
            @(posedge clk);
        end while (ready !== 1'h1);
        rd = prdata;
        err = slverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic measure(input bit pick, output int hi, output int per);
        hi = 0;
        while ((pick ? ale : so) !== 1'h1) @(posedge clk);
        while ((pick ? ale : so) === 1'h1) begin
            hi++;
            @(posedge clk);
        end
        per = hi;
        while ((pick ? ale : so) !== 1'h1) begin
            per++;
            @(posedge clk);
        end
    endtask
    task automatic pulse;
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (60) @(posedge clk);
    endtask
    task automatic t_clocks;
        int hi, per;
        apb(1'h1, timer_pkg::OFF_CTRL, 32'h4);
        repeat (2) @(posedge clk);
        check(soe_n, 1'h0);
        measure(1'h0, hi, per);
        check(hi, 1);
        check(per, timer_pkg::STATE_DIV_LAST + 1);
        measure(1'h1, hi, per);
        check(hi, timer_pkg::STATE_DIV_LAST + 1);
        check(per, (timer_pkg::STATE_DIV_LAST + 1) * (timer_pkg::CYCLE_DIV_LAST + 1));
        apb(1'h1, timer_pkg::OFF_CTRL, 32'h0);
        sense <= 1'h0;
        repeat (6) @(posedge clk);
        check(soe_n, 1'h1);
        apb(1'h0, timer_pkg::OFF_PINS, 32'h0);
        check(rd[0], 1'h0);
        sense <= 1'h1;
        $display("clock test ended");
    endtask
    task automatic t_regs;
        apb(1'h1, timer_pkg::OFF_COUNT, 32'h5a);
        apb(1'h1, timer_pkg::OFF_CTRL, 32'h1);
        rst_n <= 1'h0;
        repeat (2) @(posedge clk);
        rst_n <= 1'h1;
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h5a);
        apb(1'h0, timer_pkg::OFF_CTRL, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        check(err, 1'h1);
        check(rd, 32'h0);
        $display("register test ended");
    endtask
    task automatic t_timer;
        int k;
        apb(1'h1, timer_pkg::OFF_MASK, 32'h1);
        apb(1'h1, timer_pkg::OFF_COUNT, 32'hfe);
        apb(1'h1, timer_pkg::OFF_CTRL, 32'h1);
        repeat (440) @(posedge clk);
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'hfe);
        k = 0;
        // Two steps of 480 CLK from the start, so about 520 are left here
        while (irq !== 1'h1 && k < 1000) begin
            k++;
            @(posedge clk);
        end
        check(k > 400 && k < 560, 1'h1);
        check(vec, timer_pkg::VEC_TIMER);
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h0);
        apb(1'h0, timer_pkg::OFF_STATUS, 32'h0);
        check(rd, 32'h1);
        repeat (3) @(posedge clk);
        check(irq, 1'h0);
        repeat (480) @(posedge clk);
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h1);
        $display("timer test ended");
    endtask
    task automatic t_event;
        apb(1'h1, timer_pkg::OFF_MASK, 32'h0);
        apb(1'h1, timer_pkg::OFF_COUNT, 32'hff);
        apb(1'h1, timer_pkg::OFF_CTRL, 32'h3);
        fire <= 1'h1;
        @(posedge clk);
        fire <= 1'h0;
        repeat (10) @(posedge clk);
        apb(1'h0, timer_pkg::OFF_PINS, 32'h0);
        check(rd[1], 1'h0);
        repeat (50) @(posedge clk);
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h0);
        check(irq, 1'h0);
        apb(1'h0, timer_pkg::OFF_STATUS, 32'h0);
        check(rd, 32'h1);
        pulse;
        apb(1'h0, timer_pkg::OFF_COUNT, 32'h0);
        check(rd, 32'h1);
        apb(1'h0, timer_pkg::OFF_PINS, 32'h0);
        check(rd[1], 1'h1);
        apb(1'h0, timer_pkg::OFF_CTRL, 32'h0);
        check(rd, 32'h3);
        $display("event test ended");
    endtask
    task automatic t_ext;
        apb(1'h1, timer_pkg::OFF_COUNT, 32'hff);
        apb(1'h1, timer_pkg::OFF_MASK, 32'h3);
        ext_n <= 1'h0;
        pulse;
        check({irq, vec}, {1'h1, timer_pkg::VEC_EXT});
        apb(1'h1, timer_pkg::OFF_MASK, 32'h1);
        repeat (2) @(posedge clk);
        check({irq, vec}, {1'h1, timer_pkg::VEC_TIMER});
        ext_n <= 1'h1;
        repeat (6) @(posedge clk);
        apb(1'h0, timer_pkg::OFF_STATUS, 32'h0);
        check(rd, 32'h3);
        $display("interrupt test ended");
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_clocks;
        t_regs;
        t_timer;
        t_event;
        t_ext;
        report_and_stop;
    end
    // All tests need under 3000 CLK; a hang ends well before the run grows long
    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        report_and_stop;
    end
endmodule // test_clock_divider_timer_counter

// ### timer_counter.sv
// Clock dividers, interval timer / event counter and APB register slave
//
// Our own choices: the register addresses and the APB slave port.
module timer_counter (
    input  wire logic        CLK,
    input  wire logic        RST_N,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        SENSE_CLOCK_PIN_I,
    output logic             SENSE_CLOCK_PIN_O,
    output logic             SENSE_CLOCK_PIN_OE_N,
    input  wire logic        EVENT_SENSE_PIN,
    input  wire logic        EXT_INT_N,
    output logic             ALE,
    output logic             IRQ,
    output logic      [2:0]  IRQ_VECTOR
);
    typedef struct packed {
        logic [1:0]  state_div;
        logic [2:0]  cycle_div;
        logic [4:0]  presc;
        logic [7:0]  count;
        logic        count_loaded;
        logic        run;
        logic        evt_mode;
        logic        clk_out_en;
        logic        sense_oe_n;
        logic [1:0]  status;
        logic [1:0]  mask;
        logic [2:0]  evt_sync;
        logic [2:0]  sns_sync;
        logic [2:0]  int_sync;
        logic        evt_level;
        logic        sns_level;
        logic        int_level;
        logic        evt_prev;
        logic        state_clk;
        logic        ale;
        logic        irq;
        logic [2:0]  vector;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_t;

    state_t s;
    state_t next_s;

    logic st_en;
    logic cy_en;
    logic acc;
    logic wr;
    logic rd;
    logic inc;
    logic evt_fall;
    logic hit;
    logic [1:0] set_bits;
    logic [1:0] clr_bits;
    logic [1:0] pend;

    assign st_en = (s.state_div == timer_pkg::STATE_DIV_LAST);
    assign cy_en = st_en && (s.cycle_div == timer_pkg::CYCLE_DIV_LAST);
    assign acc = PSEL && PENABLE && s.pready;
    assign wr = acc && PWRITE;
    assign rd = acc && !PWRITE;
    // Sampled on the state clock: a fall counts if the level is high at one state enable and low at the next
    assign evt_fall = st_en && s.evt_prev && !s.evt_level;
    assign inc = s.run && (s.evt_mode ? evt_fall
                 : (cy_en && s.presc == timer_pkg::PRESC_LAST));
    assign hit = (PADDR == timer_pkg::OFF_CTRL) || (PADDR == timer_pkg::OFF_COUNT)
              || (PADDR == timer_pkg::OFF_STATUS) || (PADDR == timer_pkg::OFF_MASK)
              || (PADDR == timer_pkg::OFF_PINS);
    assign pend = s.status & s.mask;

    always_comb begin
        next_s = s;
        set_bits = 2'h0;
        clr_bits = 2'h0;
        // Dividers run free from the master clock
        next_s.state_div = st_en ? 2'h0 : s.state_div + 2'h1;
        if (st_en) begin
            next_s.cycle_div = cy_en ? 3'h0 : s.cycle_div + 3'h1;
            next_s.evt_prev = s.evt_level;
        end
        // State clock shape: high for the first master period of three
        next_s.state_clk = st_en;
        if (cy_en) begin
            next_s.ale = 1'b1;
        end else if (st_en) begin
            next_s.ale = 1'b0;
        end
        if (cy_en && s.run && !s.evt_mode) begin
            next_s.presc = s.presc + 5'h1;
        end
        // Pin synchronisers; a level counts once stages two and three agree
        next_s.evt_sync = {s.evt_sync[1:0], EVENT_SENSE_PIN};
        next_s.sns_sync = {s.sns_sync[1:0], SENSE_CLOCK_PIN_I};
        next_s.int_sync = {s.int_sync[1:0], EXT_INT_N};
        if (s.evt_sync[1] == s.evt_sync[2]) begin
            next_s.evt_level = s.evt_sync[2];
        end
        if (s.sns_sync[1] == s.sns_sync[2]) begin
            next_s.sns_level = s.sns_sync[2];
        end
        if (s.int_sync[1] == s.int_sync[2]) begin
            next_s.int_level = s.int_sync[2];
        end
        if (inc) begin
            next_s.count = s.count + 8'h01;
        end
        set_bits[timer_pkg::ST_OVF] = inc && (s.count == timer_pkg::COUNT_MAX);
        set_bits[timer_pkg::ST_EXT] = !s.int_level;
        // APB: no wait state; ready and read data are registered in the setup cycle so they come from flip-flops
        next_s.pready = PSEL && !PENABLE;
        next_s.pslverr = PSEL && !PENABLE && !hit;
        next_s.prdata = 32'h0;
        if (PSEL && !PENABLE && !PWRITE) begin
            if (PADDR == timer_pkg::OFF_CTRL) begin
                next_s.prdata[timer_pkg::CTRL_RUN] = s.run;
                next_s.prdata[timer_pkg::CTRL_EVENT] = s.evt_mode;
                next_s.prdata[timer_pkg::CTRL_CLKOUT] = s.clk_out_en;
            end else if (PADDR == timer_pkg::OFF_COUNT) begin
                next_s.prdata[7:0] = s.count;
            end else if (PADDR == timer_pkg::OFF_STATUS) begin
                next_s.prdata[1:0] = s.status;
            end else if (PADDR == timer_pkg::OFF_MASK) begin
                next_s.prdata[1:0] = s.mask;
            end else if (PADDR == timer_pkg::OFF_PINS) begin
                // Sense pin reads low while output, as the filter drops the one-period highs of its own state clock
                next_s.prdata[timer_pkg::PIN_SENSE] = s.sns_level;
                next_s.prdata[timer_pkg::PIN_EVENT] = s.evt_level;
            end
        end
        if (rd && PADDR == timer_pkg::OFF_STATUS) begin
            clr_bits = s.status;
        end
        if (wr) begin
            if (PADDR == timer_pkg::OFF_CTRL) begin
                next_s.run = PWDATA[timer_pkg::CTRL_RUN];
                next_s.evt_mode = PWDATA[timer_pkg::CTRL_EVENT];
                next_s.clk_out_en = PWDATA[timer_pkg::CTRL_CLKOUT];
                if (PWDATA[timer_pkg::CTRL_RUN] && !s.run) begin
                    next_s.presc = 5'h0;
                end
            end else if (PADDR == timer_pkg::OFF_COUNT) begin
                // A load wins over an increment in the same cycle
                next_s.count = PWDATA[7:0];
                next_s.count_loaded = 1'b1;
            end else if (PADDR == timer_pkg::OFF_MASK) begin
                next_s.mask = PWDATA[1:0];
            end
        end
        // A new event wins over the read that clears it
        next_s.status = (s.status & ~clr_bits) | set_bits;
        next_s.irq = |pend;
        // External request outranks the timer overflow
        next_s.vector = pend[timer_pkg::ST_EXT] ? timer_pkg::VEC_EXT
                      : timer_pkg::VEC_TIMER;
        // Registered so the pin enable leaves straight from a flip-flop
        next_s.sense_oe_n = !next_s.clk_out_en;
        if (!RST_N) begin
            next_s = '0;
            next_s.count = s.count;
            next_s.count_loaded = s.count_loaded;
            next_s.sense_oe_n = 1'b1;
            next_s.evt_sync = 3'h7;
            next_s.sns_sync = 3'h7;
            next_s.int_sync = 3'h7;
            next_s.evt_level = 1'b1;
            next_s.sns_level = 1'b1;
            next_s.int_level = 1'b1;
            next_s.evt_prev = 1'b1;
            next_s.vector = timer_pkg::VEC_TIMER;
        end
    end

    always_ff @(posedge CLK) begin
        s <= next_s;
    end

    assign PRDATA = s.prdata;
    assign PREADY = s.pready;
    assign PSLVERR = s.pslverr;
    assign SENSE_CLOCK_PIN_O = s.state_clk;
    assign SENSE_CLOCK_PIN_OE_N = s.sense_oe_n;
    assign ALE = s.ale;
    assign IRQ = s.irq;
    assign IRQ_VECTOR = s.vector;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    a_state_rate: assert property (st_en |=> !st_en ##1 !st_en ##1 st_en)
        else $error("state enable not every third clock");

    // The fourteen quiet cycles are checked as eight plus six to keep unrolling small
    a_cycle_rate: assert property (cy_en |=> (!cy_en)[*8]
        ##1 (!cy_en)[*6] ##1 cy_en)
        else $error("cycle enable not every fifteenth clock");

    a_ale_width: assert property (cy_en |=> ALE[*3] ##1 !ALE)
        else $error("strobe not one state period wide");

    a_ale_start: assert property (!ALE && !cy_en |=> !ALE)
        else $error("strobe rose off the cycle clock");

    a_sense_shape: assert property (st_en |=> SENSE_CLOCK_PIN_O
        ##1 !SENSE_CLOCK_PIN_O ##1 !SENSE_CLOCK_PIN_O)
        else $error("state clock on sense pin misshaped");

    a_sense_drive: assert property (wr && PADDR == timer_pkg::OFF_CTRL |=>
        SENSE_CLOCK_PIN_OE_N == !$past(PWDATA[timer_pkg::CTRL_CLKOUT]))
        else $error("sense pin enable wrong");

    a_sense_hold: assert property (!(wr && PADDR == timer_pkg::OFF_CTRL) |=>
        $stable(SENSE_CLOCK_PIN_OE_N))
        else $error("sense pin enable moved without a write");

    // A count never loaded since power-up is undefined, so it is left unjudged
    a_count_keep: assert property (disable iff (1'b0)
        !RST_N && s.count_loaded |=> s.count == $past(s.count))
        else $error("counter changed by reset");

    a_count_load: assert property (wr && PADDR == timer_pkg::OFF_COUNT |=>
        s.count == $past(PWDATA[7:0]))
        else $error("counter load lost");

    a_count_hold: assert property (!inc && !wr |=> $stable(s.count))
        else $error("counter moved without a step or load");

    a_stop_hold: assert property (!s.run && !wr |=> $stable(s.count))
        else $error("stopped counter moved");

    a_mode_set: assert property (wr && PADDR == timer_pkg::OFF_CTRL |=>
        s.run == $past(PWDATA[timer_pkg::CTRL_RUN])
        && s.evt_mode == $past(PWDATA[timer_pkg::CTRL_EVENT]))
        else $error("control write not taken");

    a_timer_step: assert property (s.run && !s.evt_mode && cy_en
        && s.presc == timer_pkg::PRESC_LAST && !wr |=> s.count == $past(s.count) + 8'h01)
        else $error("timer step off prescaler");

    a_timer_gate: assert property (!s.evt_mode && !wr
        && !(cy_en && s.presc == timer_pkg::PRESC_LAST) |=> $stable(s.count))
        else $error("timer stepped between prescaler wraps");

    a_presc_step: assert property (s.run && !s.evt_mode && cy_en && !wr |=>
        s.presc == $past(s.presc) + 5'h01)
        else $error("prescaler missed a cycle");

    a_presc_idle: assert property (!cy_en && !wr |=> $stable(s.presc))
        else $error("prescaler moved off the cycle clock");

    a_presc_clear: assert property (wr && PADDR == timer_pkg::OFF_CTRL
        && PWDATA[timer_pkg::CTRL_RUN] && !s.run |=> s.presc == 5'h00)
        else $error("prescaler not cleared at start");

    a_wrap_flag: assert property (inc && s.count == timer_pkg::COUNT_MAX && !wr |=>
        s.count == 8'h00 && s.status[timer_pkg::ST_OVF])
        else $error("wrap did not flag overflow");

    a_ovf_only: assert property ($rose(s.status[timer_pkg::ST_OVF]) |-> $past(inc))
        else $error("overflow flag without wrap");

    a_ovf_sticky: assert property (s.status[timer_pkg::ST_OVF]
        && !(rd && PADDR == timer_pkg::OFF_STATUS) |=> s.status[timer_pkg::ST_OVF])
        else $error("overflow flag dropped without a read");

    a_ovf_clear: assert property (rd && PADDR == timer_pkg::OFF_STATUS && !inc |=>
        !s.status[timer_pkg::ST_OVF])
        else $error("status read left overflow set");

    a_ext_set: assert property (!s.int_level |=> s.status[timer_pkg::ST_EXT])
        else $error("external request not latched");

    a_event_step: assert property (s.run && s.evt_mode && st_en && s.evt_prev
        && !s.evt_level && !wr |=> s.count == $past(s.count) + 8'h01)
        else $error("event edge not counted");

    a_event_gate: assert property (s.evt_mode && !evt_fall && !wr |=> $stable(s.count))
        else $error("event counter moved without an edge");

    a_event_prev: assert property (st_en |=> s.evt_prev == $past(s.evt_level))
        else $error("event sample not taken on the state clock");

    a_event_idle: assert property (!st_en |=> $stable(s.evt_prev))
        else $error("event sample moved between state clocks");

    a_level_hold: assert property (s.evt_sync[1] != s.evt_sync[2] |=> $stable(s.evt_level))
        else $error("event level moved while stages disagree");

    a_pin_event: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR == timer_pkg::OFF_PINS |=>
        PRDATA[timer_pkg::PIN_EVENT] == $past(s.evt_level))
        else $error("event pin level misread");

    a_pin_sense: assert property (PSEL && !PENABLE && !PWRITE
        && PADDR == timer_pkg::OFF_PINS |=>
        PRDATA[timer_pkg::PIN_SENSE] == $past(s.sns_level))
        else $error("sense pin level misread");

    a_irq_on: assert property ((|pend) |=> IRQ)
        else $error("interrupt missing for a pending flag");

    a_irq_off: assert property (!(|pend) |=> !IRQ)
        else $error("interrupt raised with nothing pending");

    a_ext_first: assert property (pend[timer_pkg::ST_EXT] |=>
        IRQ_VECTOR == timer_pkg::VEC_EXT && IRQ)
        else $error("external request not first");

    a_timer_vec: assert property (!pend[timer_pkg::ST_EXT] |=>
        IRQ_VECTOR == timer_pkg::VEC_TIMER)
        else $error("timer vector missing");

    // No wait state on any access; read data still always leaves a flip-flop
    a_ready_wait: assert property (PSEL && !PENABLE |=> PREADY)
        else $error("ready missing after setup");

    a_ready_idle: assert property (!(PSEL && !PENABLE) |=>
        !PREADY && !PSLVERR && PRDATA == 32'h0)
        else $error("bus answer outside an access");

    a_bad_addr: assert property (PSEL && !PENABLE && !hit |=> PSLVERR && PRDATA == 32'h0)
        else $error("unmapped address not refused");
endmodule // timer_counter

// ### timer_pkg.sv
// Constants for the clock divider and timer/counter block
package timer_pkg;
    localparam logic [1:0]  STATE_DIV_LAST = 2'h2;   // Master clock / 3
    localparam logic [2:0]  CYCLE_DIV_LAST = 3'h4;   // State clock / 5
    localparam logic [4:0]  PRESC_LAST     = 5'h1f;  // Cycle clock / 32
    localparam logic [7:0]  COUNT_MAX      = 8'hff;
    localparam logic [2:0]  VEC_EXT        = 3'h3;
    localparam logic [2:0]  VEC_TIMER      = 3'h7;
    localparam logic [11:0] OFF_CTRL       = 12'h000;
    localparam logic [11:0] OFF_COUNT      = 12'h004;
    localparam logic [11:0] OFF_STATUS     = 12'h008;
    localparam logic [11:0] OFF_MASK       = 12'h00c;
    localparam logic [11:0] OFF_PINS       = 12'h010;
    localparam int          CTRL_RUN       = 0;
    localparam int          CTRL_EVENT     = 1;
    localparam int          CTRL_CLKOUT    = 2;
    localparam int          ST_OVF         = 0;
    localparam int          ST_EXT         = 1;
    localparam int          PIN_SENSE      = 0;
    localparam int          PIN_EVENT      = 1;
    // Far side event pin figures, kept for reference; the bench does not use them
    localparam int          EVENT_MIN_PULSE_NS = 500;
    localparam int          CLK_PERIOD_NS      = 25;
    localparam int          EVENT_MIN_PULSE_CYC =
        (EVENT_MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
